// ---- core/cspd_ctrl.sv ----
// Contract
// - clock pin: clock when enabled, high when disabled or standby, off in hw standby; the code keeps it driven while reset is also low.
// - select code 000 full speed, 001..101 divide by 2..32, 11x undefined.
// - a divider derives system clock /2, /4, /8, /16 and /32.
// - divided clock only reaches bus masters; other modules stay on full clock.
// - after reset the block is full speed with no power-down mode; the code leaves module stop bits 13..0 set (0x3FFF).
// - halt enters sleep when standby select is 0, software standby when 1.
// - standby select stays 1 after interrupt wake; software writes 0 to clear.
// - wake-wait code picks 8192..262144 states, 110 reserved, 111 gives 16.
// - in standby, bus outputs float when output hold is 0, else keep state.
// - serial and converter modules reset in module stop and standby; serial reset in module stop only when all three serial stop bits are set.
// - standby control loads 0x08 on reset and hw standby, kept in standby.
// - clock control loads 0x00 on reset and hw standby, kept in standby.
// - medium speed, sleep and module stop are independent controls.
// - standby control bits 2,1 read 0; bit 0 stored.
// - clock select change takes effect at end of the current bus cycle.
// - module stop bits act at end of the bus cycle.
// - interrupt wake waits the selected states before clocks resume.
//
// Register access over Avalon-MM was chosen for this implementation.
module cspd_ctrl (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_hw_standby_n,
    input wire logic [15:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    input wire logic i_bus_cycle_end,
    input wire logic i_halt,
    input wire logic i_ext_wake,
    output logic o_clock_pin,
    output logic o_clock_pin_oe,
    output logic o_master_clock_en,
    output logic o_module_clock_en,
    output logic o_sleep,
    output logic o_soft_standby,
    output logic o_bus_pins_oe_n,
    output logic [15:0] o_module_stop,
    output logic o_serial_reset,
    output logic o_adc_reset,
    output logic o_wake_irq
);
    logic [7:0] standby_control;
    logic [7:0] system_clock_control;
    logic [15:0] module_stop;
    logic [2:0] active_select;
    logic [15:0] active_stop;
    logic [4:0] div_count;
    logic [18:0] wait_count;
    logic sleep;
    logic phase;
    cspd_pkg::cspd_state_t state;
    logic init;
    logic wr_ack;
    logic rd_take;
    logic go_sleep;
    logic go_standby;
    logic halt_cmd;
    logic wake_cmd;
    logic halt_req;
    logic wake_req;
    logic next_master_en;

    function automatic logic [18:0] wait_states(input logic [2:0] code);
        case (code)
            3'h0: wait_states = cspd_pkg::WAIT_CODE0;
            3'h1: wait_states = cspd_pkg::WAIT_CODE1;
            3'h2: wait_states = cspd_pkg::WAIT_CODE2;
            3'h3: wait_states = cspd_pkg::WAIT_CODE3;
            3'h4: wait_states = cspd_pkg::WAIT_CODE4;
            3'h5: wait_states = cspd_pkg::WAIT_CODE5;
            3'h7: wait_states = cspd_pkg::WAIT_CODE7;
            default: wait_states = cspd_pkg::WAIT_CODE0;
        endcase
    endfunction

    // mask of divider bits that must be all ones for a tick
    function automatic logic [4:0] div_mask(input logic [2:0] code);
        case (code)
            3'h1: div_mask = 5'h01;
            3'h2: div_mask = 5'h03;
            3'h3: div_mask = 5'h07;
            3'h4: div_mask = 5'h0F;
            3'h5: div_mask = 5'h1F;
            default: div_mask = 5'h00;
        endcase
    endfunction

    assign init = !i_rst_n || !i_hw_standby_n;
    assign wr_ack = i_write && !o_waitrequest;
    // read data is fetched in the wait cycle so it stands when waitrequest drops
    assign rd_take = i_read && o_waitrequest;
    assign halt_cmd = wr_ack && i_address == cspd_pkg::ADDR_POWER_COMMAND
        && i_writedata[cspd_pkg::CMD_HALT];
    assign wake_cmd = wr_ack && i_address == cspd_pkg::ADDR_POWER_COMMAND
        && i_writedata[cspd_pkg::CMD_WAKE];
    assign halt_req = i_halt || halt_cmd;
    assign wake_req = i_ext_wake || wake_cmd;
    assign go_standby = state == cspd_pkg::CSPD_RUN && !sleep && halt_req
        && standby_control[cspd_pkg::SBC_STANDBY_SELECT];
    assign go_sleep = state == cspd_pkg::CSPD_RUN && !sleep && halt_req
        && !standby_control[cspd_pkg::SBC_STANDBY_SELECT];

    // one wait state per access
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_waitrequest <= 1'b1;
        end else if ((i_read || i_write) && o_waitrequest) begin
            o_waitrequest <= 1'b0;
        end else begin
            o_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            standby_control <= cspd_pkg::RST_STANDBY_CONTROL;
        end else if (wr_ack && i_address == cspd_pkg::ADDR_STANDBY_CONTROL) begin
            standby_control <= i_writedata[7:0] & cspd_pkg::SBC_WRITE_MASK;
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            system_clock_control <= cspd_pkg::RST_SYSTEM_CLOCK_CONTROL;
        end else if (wr_ack && i_address == cspd_pkg::ADDR_SYSTEM_CLOCK_CONTROL) begin
            system_clock_control <= i_writedata[7:0] & cspd_pkg::SCC_WRITE_MASK;
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            module_stop <= {cspd_pkg::RST_MODULE_STOP_HIGH, cspd_pkg::RST_MODULE_STOP_LOW};
        end else if (wr_ack) begin
            if (i_address == cspd_pkg::ADDR_MODULE_STOP_HIGH) begin
                module_stop[15:8] <= i_writedata[7:0];
            end else if (i_address == cspd_pkg::ADDR_MODULE_STOP_LOW) begin
                module_stop[7:0] <= i_writedata[7:0];
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            o_readdata <= 32'h0000_0000;
        end else if (rd_take) begin
            if (i_address == cspd_pkg::ADDR_STANDBY_CONTROL) begin
                o_readdata <= {24'h000000, standby_control};
            end else if (i_address == cspd_pkg::ADDR_SYSTEM_CLOCK_CONTROL) begin
                o_readdata <= {24'h000000, system_clock_control};
            end else if (i_address == cspd_pkg::ADDR_MODULE_STOP_HIGH) begin
                o_readdata <= {24'h000000, module_stop[15:8]};
            end else if (i_address == cspd_pkg::ADDR_MODULE_STOP_LOW) begin
                o_readdata <= {24'h000000, module_stop[7:0]};
            end else if (i_address == cspd_pkg::ADDR_POWER_STATUS) begin
                o_readdata <= {21'h000000, active_select, 5'h00, state == cspd_pkg::CSPD_WAKE_WAIT,
                    state == cspd_pkg::CSPD_STANDBY, sleep};
            end else begin
                o_readdata <= 32'h0000_0000;
            end
        end
    end

    // settings move to the active copy only at a bus cycle boundary
    always_ff @(posedge i_clock) begin
        if (init) begin
            active_select <= 3'h0;
        end else if (i_bus_cycle_end) begin
            active_select <= system_clock_control[2:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            active_stop <= {cspd_pkg::RST_MODULE_STOP_HIGH, cspd_pkg::RST_MODULE_STOP_LOW};
        end else if (i_bus_cycle_end) begin
            active_stop <= module_stop;
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            div_count <= 5'h00;
        end else begin
            div_count <= div_count + 5'h01;
        end
    end

    // whole-cycle enable pulses, so a code switch never shortens a phase
    always_comb begin
        next_master_en = 1'b1;
        if (active_select >= 3'h6) begin
            next_master_en = 1'b0;
        end else if (active_select != 3'h0) begin
            next_master_en = (div_count & div_mask(active_select))
                == div_mask(active_select);
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            o_master_clock_en <= 1'b1;
        end else begin
            o_master_clock_en <= next_master_en && state == cspd_pkg::CSPD_RUN && !sleep;
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            o_module_clock_en <= 1'b1;
        end else begin
            o_module_clock_en <= state == cspd_pkg::CSPD_RUN;
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            state <= cspd_pkg::CSPD_RUN;
        end else begin
            case (state)
                cspd_pkg::CSPD_RUN: begin
                    if (go_standby) begin
                        state <= cspd_pkg::CSPD_STANDBY;
                    end
                end
                cspd_pkg::CSPD_STANDBY: begin
                    if (wake_req) begin
                        state <= cspd_pkg::CSPD_WAKE_WAIT;
                    end
                end
                cspd_pkg::CSPD_WAKE_WAIT: begin
                    if (wait_count <= cspd_pkg::WAIT_LAST) begin
                        state <= cspd_pkg::CSPD_RUN;
                    end
                end
                default: begin
                    state <= cspd_pkg::CSPD_RUN;
                end
            endcase
        end
    end

    // a halt while asleep is ignored, so sleep and standby never overlap
    always_ff @(posedge i_clock) begin
        if (init) begin
            sleep <= 1'b0;
        end else if (sleep && wake_req) begin
            sleep <= 1'b0;
        end else if (go_sleep) begin
            sleep <= 1'b1;
        end
    end

    // stabilisation counter, loaded by the wake request that ends standby
    always_ff @(posedge i_clock) begin
        if (init) begin
            wait_count <= 19'h00000;
        end else if (state == cspd_pkg::CSPD_STANDBY && wake_req) begin
            wait_count <= wait_states(
                standby_control[cspd_pkg::SBC_WAKE_WAIT_HI:cspd_pkg::SBC_WAKE_WAIT_LO]);
        end else if (state == cspd_pkg::CSPD_WAKE_WAIT && wait_count > cspd_pkg::WAIT_LAST) begin
            wait_count <= wait_count - 19'h00001;
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            o_wake_irq <= 1'b0;
        end else begin
            o_wake_irq <= state == cspd_pkg::CSPD_WAKE_WAIT && wait_count <= 19'd1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            o_sleep <= 1'b0;
        end else begin
            o_sleep <= sleep;
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            o_soft_standby <= 1'b0;
        end else begin
            o_soft_standby <= state != cspd_pkg::CSPD_RUN;
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            o_bus_pins_oe_n <= 1'b0;
        end else begin
            o_bus_pins_oe_n <= state != cspd_pkg::CSPD_RUN
                && !standby_control[cspd_pkg::SBC_OUTPUT_HOLD];
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            o_module_stop <= {cspd_pkg::RST_MODULE_STOP_HIGH, cspd_pkg::RST_MODULE_STOP_LOW};
        end else begin
            o_module_stop <= active_stop;
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            o_serial_reset <= 1'b1;
        end else begin
            o_serial_reset <= state != cspd_pkg::CSPD_RUN
                || &active_stop[cspd_pkg::MODULE_STOP_BIT_SERIAL2:cspd_pkg::MODULE_STOP_BIT_SERIAL0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (init) begin
            o_adc_reset <= 1'b1;
        end else begin
            o_adc_reset <= state != cspd_pkg::CSPD_RUN || active_stop[cspd_pkg::MODULE_STOP_BIT_ADC];
        end
    end

    // clock pin shows system clock as a half-rate toggle
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            phase <= 1'b0;
        end else begin
            phase <= !phase;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_clock_pin_oe <= 1'b1;
        end else begin
            o_clock_pin_oe <= i_hw_standby_n;
        end
    end

    // held high in hardware standby so the floating pin has a known level
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || !i_hw_standby_n) begin
            o_clock_pin <= 1'b1;
        end else begin
            o_clock_pin <= system_clock_control[cspd_pkg::SCC_CLOCK_OUT_DISABLE]
                || state != cspd_pkg::CSPD_RUN || phase;
        end
    end
endmodule

// ---- core/cspd_pkg.sv ----
package cspd_pkg;
    // register byte addresses (low 16 bits of the map)
    localparam logic [15:0] ADDR_STANDBY_CONTROL = 16'hFF38;
    localparam logic [15:0] ADDR_SYSTEM_CLOCK_CONTROL = 16'hFF3A;
    localparam logic [15:0] ADDR_MODULE_STOP_HIGH = 16'hFF3C;
    localparam logic [15:0] ADDR_MODULE_STOP_LOW = 16'hFF3D;
    localparam logic [15:0] ADDR_POWER_STATUS = 16'hFF40;
    localparam logic [15:0] ADDR_POWER_COMMAND = 16'hFF44;

    localparam logic [7:0] RST_STANDBY_CONTROL = 8'h08;
    localparam logic [7:0] RST_SYSTEM_CLOCK_CONTROL = 8'h00;
    localparam logic [7:0] RST_MODULE_STOP_HIGH = 8'h3F;
    localparam logic [7:0] RST_MODULE_STOP_LOW = 8'hFF;

    // standby_control fields
    localparam int SBC_STANDBY_SELECT = 7;
    localparam int SBC_WAKE_WAIT_HI = 6;
    localparam int SBC_WAKE_WAIT_LO = 4;
    localparam int SBC_OUTPUT_HOLD = 3;
    localparam logic [7:0] SBC_WRITE_MASK = 8'hF9;
    // system_clock_control fields
    localparam int SCC_CLOCK_OUT_DISABLE = 7;
    localparam logic [7:0] SCC_WRITE_MASK = 8'hC7;

    // module stop bit positions of the modules reset in standby
    localparam int MODULE_STOP_BIT_ADC = 9;
    localparam int MODULE_STOP_BIT_SERIAL2 = 7;
    localparam int MODULE_STOP_BIT_SERIAL0 = 5;

    localparam int DIV_WIDTH = 5;
    localparam int WAIT_WIDTH = 19;
    // wake wait lengths in states, by wake_wait_select code
    localparam logic [18:0] WAIT_CODE0 = 19'h02000;
    localparam logic [18:0] WAIT_CODE1 = 19'h04000;
    localparam logic [18:0] WAIT_CODE2 = 19'h08000;
    localparam logic [18:0] WAIT_CODE3 = 19'h10000;
    localparam logic [18:0] WAIT_CODE4 = 19'h20000;
    localparam logic [18:0] WAIT_CODE5 = 19'h40000;
    localparam logic [18:0] WAIT_CODE7 = 19'h00010;
    localparam logic [18:0] WAIT_LAST = 19'h00001;

    // power_command bits
    localparam int CMD_HALT = 0;
    localparam int CMD_WAKE = 1;

    typedef enum logic [2:0] {
        CSPD_RUN = 3'b001,
        CSPD_STANDBY = 3'b010,
        CSPD_WAKE_WAIT = 3'b100
    } cspd_state_t;
endpackage

// ---- testbench/cspd_ctrl_checker.sv ----
module cspd_ctrl_checker (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_hw_standby_n,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic o_waitrequest,
    input wire logic o_clock_pin,
    input wire logic o_clock_pin_oe,
    input wire logic o_master_clock_en,
    input wire logic o_module_clock_en,
    input wire logic o_sleep,
    input wire logic o_soft_standby,
    input wire logic o_bus_pins_oe_n,
    input wire logic o_serial_reset,
    input wire logic o_adc_reset,
    input wire logic o_wake_irq
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    AST_WAIT_ONE: assert property ($rose(i_read || i_write) |=> !o_waitrequest)
        else $error("no answer one cycle after request");
    AST_WAIT_DROP: assert property (!o_waitrequest |=> o_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_PIN_HIGH: assert property (o_soft_standby && $past(o_soft_standby) |-> o_clock_pin)
        else $error("clock pin not high in standby");
    AST_HW_FLOAT: assert property (!i_hw_standby_n |=> !o_clock_pin_oe)
        else $error("clock pin driven in hardware standby");
    AST_EXCL: assert property (!(o_sleep && o_soft_standby))
        else $error("sleep and standby together");
    AST_SLEEP_MODS: assert property (o_sleep |-> o_module_clock_en)
        else $error("modules stopped in sleep");
    AST_STBY_RESET: assert property (o_soft_standby && $past(o_soft_standby)
        |-> o_serial_reset && o_adc_reset)
        else $error("serial or converter not reset in standby");
    AST_RUN_DRIVE: assert property (!o_soft_standby && !$past(o_soft_standby)
        && i_hw_standby_n && $past(i_hw_standby_n) |-> !o_bus_pins_oe_n)
        else $error("bus pins float outside standby");
    AST_WAKE_ONE: assert property (o_wake_irq |=> !o_wake_irq)
        else $error("wake pulse longer than one cycle");
    AST_RESET_FULL: assert property (disable iff (1'b0) $rose(i_rst_n)
        |-> o_master_clock_en && !o_sleep && !o_soft_standby)
        else $error("not full speed after reset");
    cover property (o_wake_irq);
    cover property (o_sleep);
    cover property ($rose(o_soft_standby));
endmodule

bind cspd_ctrl cspd_ctrl_checker u_cspd_ctrl_checker (.*);

// ---- testbench/test_cspd_ctrl.sv ----
module test_cspd_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 0, i_rst_n = 0, i_hw_standby_n = 1, i_read = 0, i_write = 0;
    logic i_bus_cycle_end = 0, i_halt = 0, i_ext_wake = 0;
    logic [15:0] i_address = 16'h0000;
    logic [31:0] i_writedata = 32'h00000000;
    logic [31:0] o_readdata;
    logic [15:0] o_module_stop;
    logic o_waitrequest, o_clock_pin, o_clock_pin_oe, o_master_clock_en, o_module_clock_en;
    logic o_sleep, o_soft_standby, o_bus_pins_oe_n, o_serial_reset, o_adc_reset, o_wake_irq;
    int num_errors = 0;
    int compares = 0;
    logic [31:0] seed = 32'h0000BEB5;
    logic [7:0] mdl [4] = '{8'h08, 8'h00, 8'h3F, 8'hFF};
    logic [7:0] msk [4] = '{8'hF9, 8'hC7, 8'hFF, 8'hFF};
    logic [15:0] adr [4] = '{cspd_pkg::ADDR_STANDBY_CONTROL, cspd_pkg::ADDR_SYSTEM_CLOCK_CONTROL,
        cspd_pkg::ADDR_MODULE_STOP_HIGH, cspd_pkg::ADDR_MODULE_STOP_LOW};

    cspd_ctrl u_cspd_ctrl (.*);

    initial forever #5 i_clock = ~i_clock;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(bit wr, logic [15:0] a, logic [31:0] d, output logic [31:0] q);
        i_address <= a;
        i_writedata <= d;
        i_read <= !wr;
        i_write <= wr;
        do @(posedge i_clock); while (o_waitrequest !== 1'b0);
        q = o_readdata;
        i_read <= 0;
        i_write <= 0;
        @(posedge i_clock);
    endtask

    task automatic pulse(int w);
        if (w == 0) i_halt <= 1;
        else if (w == 1) i_ext_wake <= 1;
        else i_bus_cycle_end <= 1;
        @(posedge i_clock);
        i_halt <= 0;
        i_ext_wake <= 0;
        i_bus_cycle_end <= 0;
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        logic [31:0] q;
        logic [7:0] v;
        int c, m, k, w, p;
        repeat (6) @(posedge i_clock);
        i_rst_n <= 1;
        @(posedge i_clock);
        for (k = 0; k < 4; k++) begin
            bus(0, adr[k], 0, q);
            chk("reset value", {24'h000000, mdl[k]}, q);
        end
        bus(1, 16'hFF50, 32'h000000FF, q);
        bus(0, 16'hFF50, 0, q);
        chk("unmapped read", 0, q);
        for (k = 0; k < 4; k++) begin
            v = xs();
            bus(1, adr[k], {24'h000000, v}, q);
            mdl[k] = v & msk[k];
            bus(0, adr[k], 0, q);
            chk("register readback", {24'h000000, mdl[k]}, q);
        end
        chk("module stop held", 32'h00003FFF, o_module_stop);
        pulse(2);
        repeat (2) @(posedge i_clock);
        chk("module stop", {mdl[2], mdl[3]}, o_module_stop);
        $display("test registers done");
        for (k = 0; k < 7; k++) begin
            bus(1, adr[1], k, q);
            pulse(2);
            repeat (8) @(posedge i_clock);
            c = 0;
            m = 0;
            p = 0;
            repeat (64) begin
                @(posedge i_clock);
                c += o_master_clock_en;
                m += o_module_clock_en;
                p += o_clock_pin;
            end
            chk("clock pin", 32, p);
            chk("master enables", k < 6 ? 64 >> k : 0, c);
            chk("module enables", 64, m);
        end
        bus(1, adr[1], 0, q);
        bus(1, adr[3], 0, q);
        pulse(2);
        $display("test divider done");
        bus(1, adr[0], 32'h00000008, q);
        pulse(0);
        repeat (3) @(posedge i_clock);
        chk("sleep", 2'b10, {o_sleep, o_soft_standby});
        pulse(1);
        repeat (3) @(posedge i_clock);
        chk("sleep cleared", 0, o_sleep);
        bus(1, cspd_pkg::ADDR_POWER_COMMAND, 32'h00000001, q);
        bus(0, cspd_pkg::ADDR_POWER_STATUS, 0, q);
        chk("status sleep", 32'h00000001, q);
        bus(1, cspd_pkg::ADDR_POWER_COMMAND, 32'h00000002, q);
        bus(0, cspd_pkg::ADDR_POWER_STATUS, 0, q);
        chk("status awake", 0, q);
        for (k = 0; k < 2; k++) begin
            v = {1'b1, k ? 3'b000 : 3'b111, k[0], 3'b000};
            w = k ? 8192 : 16;
            bus(1, adr[0], {24'h000000, v}, q);
            pulse(0);
            repeat (3) @(posedge i_clock);
            chk("standby", 2'b01, {o_sleep, o_soft_standby});
            chk("standby pin", 1, o_clock_pin);
            chk("bus float", !k[0], o_bus_pins_oe_n);
            chk("serial reset", 2'b11, {o_serial_reset, o_adc_reset});
            pulse(1);
            c = 1;
            while (o_wake_irq !== 1'b1 && c < 300000) begin
                @(posedge i_clock);
                c++;
            end
            chk("wake wait", 1, c >= w - 1 && c <= w + 4);
            repeat (3) @(posedge i_clock);
            bus(0, adr[0], 0, q);
            chk("select kept", {24'h000000, v}, q);
        end
        $display("test standby done");
        bus(1, adr[1], 32'h00000080, q);
        pulse(2);
        repeat (4) @(posedge i_clock);
        c = 0;
        repeat (8) begin
            @(posedge i_clock);
            c += o_clock_pin;
        end
        chk("pin disabled", 8, c);
        i_hw_standby_n <= 0;
        repeat (3) @(posedge i_clock);
        chk("pin float", 0, o_clock_pin_oe);
        i_hw_standby_n <= 1;
        @(posedge i_clock);
        bus(0, adr[1], 0, q);
        chk("hw standby clear", 0, q);
        $display("test clock pin done");
        print_verdict();
    end

    initial begin
        #400000;
        num_errors++;
        print_verdict();
    end
endmodule
